// ==== hdl/sdc_params.svh ====
// constants for the sdram command spacing block: codes, gaps, timings
// assumes a 25 MHz controller clock shared with the far end
`ifndef SDC_PARAMS_SVH
`define SDC_PARAMS_SVH

// clock
`define SDC_CLK_MHZ 25
`define SDC_CLK_NS 40

// spacing figures in clocks
`define SDC_BURST_STOP_GAP 1
`define SDC_COLUMN_CMD_GAP 1
`define SDC_DATA_TO_COLUMN_GAP 1
`define SDC_SUSPEND_ENTRY_LAT 1
`define SDC_SUSPEND_EXIT_LAT 1
`define SDC_DATA_TO_ACTIVATE_GAP 5
`define SDC_DATA_TO_PRECHARGE_GAP 2
`define SDC_WRITE_MASK_LAT 0
`define SDC_READ_MASK_OFF_LAT 2
`define SDC_WRITE_DATA_DELAY 0
`define SDC_MODE_LOAD_GAP 2
`define SDC_PRECHARGE_OFF_CL3 3
`define SDC_PRECHARGE_OFF_CL2 2
`define SDC_SREF_EXIT_EDGES 2

// analog times and derived clock counts (least times round up)
`define SDC_WRITE_RECOVERY_NS 15
`define SDC_PRECHARGE_PERIOD_NS 18
`define SDC_WRITE_RECOVERY_CYC ((`SDC_WRITE_RECOVERY_NS + `SDC_CLK_NS - 1) / `SDC_CLK_NS)
`define SDC_PRECHARGE_PERIOD_CYC ((`SDC_PRECHARGE_PERIOD_NS + `SDC_CLK_NS - 1) / `SDC_CLK_NS)

// refresh budget
`define SDC_REFRESH_WINDOW_MS 64
`define SDC_REFRESH_COUNT 8192
`define SDC_REFRESH_WINDOW_CYC (`SDC_REFRESH_WINDOW_MS * 1000 * `SDC_CLK_MHZ)

// mode word fields and auto precharge bit on the address pins
`define SDC_MODE_BL_LSB 0
`define SDC_MODE_CL_LSB 4
`define SDC_AP_BIT 10

// command codes as {cs_n, ras_n, cas_n, we_n}
`define SDC_CODE_NOP 4'h7
`define SDC_CODE_ACTIVE 4'h3
`define SDC_CODE_READ 4'h5
`define SDC_CODE_WRITE 4'h4
`define SDC_CODE_BST 4'h6
`define SDC_CODE_PRECH 4'h2
`define SDC_CODE_REFRESH 4'h1
`define SDC_CODE_LMR 4'h0

// reset values
`define SDC_RESET_CL3 1'b1
`define SDC_RESET_BL 4'h1

`endif

// ==== hdl/sdc_pkg.sv ====
// types shared by the sdram command spacing modules
// assumes sdc_params.svh supplies the numeric constants
package sdc_pkg;
    typedef enum logic [3:0] {
        CMD_INHIBIT, CMD_NOP, CMD_ACTIVE, CMD_READ, CMD_WRITE,
        CMD_BST, CMD_PRECH, CMD_REFRESH, CMD_LMR
    } sdc_cmd_t;
    typedef enum logic [1:0] {PW_RUN, PW_SUSPEND, PW_SELFREF} sdc_pwr_t;
endpackage

// ==== hdl/sdc_rd_if.sv ====
// read path bundle between the command logic and the output pipeline
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface sdc_rd_if #(parameter int DW = 32);
    logic fire;
    logic adv;
    logic cl3;
    logic [DW-1:0] data;
    logic [DW/8-1:0] mask;
    logic [DW-1:0] dq_o;
    logic [DW/8-1:0] dq_oe;
    modport ctl (output fire, adv, cl3, data, mask, input dq_o, dq_oe);
    modport pipe (input fire, adv, cl3, data, mask, output dq_o, dq_oe);
endinterface

// ==== hdl/sdc_rd_pipe.sv ====
// read data pipeline: latency 2 or 3, byte mask turn-off, suspend hold
// assumes fire and data are taken on the command edge of each element
`timescale 1ns/1ps
module sdc_rd_pipe import sdc_pkg::*; #(
    parameter int DW = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // read bundle
    sdc_rd_if.pipe rd
);
    localparam int NB = DW / 8;

    logic [1:0] vld_ff;
    logic [DW-1:0] sh_ff [0:1];
    logic [NB-1:0] mask_ff;
    logic [DW-1:0] dq_o_ff;
    logic [NB-1:0] oe_ff;

    // element shift stages, frozen while the clock gate holds
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            vld_ff <= 2'h0;
            sh_ff[0] <= '0;
            sh_ff[1] <= '0;
        end else if (rd.adv) begin
            vld_ff <= {vld_ff[0], rd.fire};
            sh_ff[0] <= rd.data;
            sh_ff[1] <= sh_ff[0];
        end
    end

    // mask stage gives the two-clock turn-off
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mask_ff <= '0;
        end else if (rd.adv) begin
            mask_ff <= rd.mask;
        end
    end

    // output flops pick the stage that matches the latency
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dq_o_ff <= '0;
            oe_ff <= '0;
        end else if (rd.adv) begin
            dq_o_ff <= rd.cl3 ? sh_ff[1] : sh_ff[0];
            oe_ff <= (rd.cl3 ? vld_ff[1] : vld_ff[0]) ? ~mask_ff : '0;
        end
    end

    assign rd.dq_o = dq_o_ff;
    assign rd.dq_oe = oe_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_mask_turnoff;
        (rd.adv && rd.mask[0]) ##1 rd.adv |=> !oe_ff[0];
    endproperty
    a_mask_turnoff: assert property (p_mask_turnoff)
        else $error("masked read byte still driven two clocks later");
endmodule // sdc_rd_pipe

// ==== hdl/sdc_device.sv ====
// sdram device core: command decode, bursts, clock gate, spacing checks
// assumes the controller shares clk and drives pins on that clock
`timescale 1ns/1ps
`include "sdc_params.svh"

// Notes on behaviour
// - read or write commands may be issued every clock
// - clock gate sampled low suspends the device one clock later
// - write byte mask blocks data on the same edge it is sampled
// - read byte mask turns data outputs off two clocks after sampling
// - first write data is taken on the write command edge
// - clock gate back high resumes command taking one clock later
// - precharge during read turns outputs off after read latency clocks
// - auto precharge timing starts one clock after last write data
// - activate is cs low, ras low, cas high, we high
// - write is cs low, ras high, cas low, we low
module sdc_device import sdc_pkg::*; #(
    parameter int DW = 32,
    parameter int AW = 13,
    parameter int COL_BITS = 4,
    parameter int REF_WINDOW_CYC = `SDC_REFRESH_WINDOW_CYC,
    parameter int REF_COUNT = `SDC_REFRESH_COUNT
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // command pins
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [1:0] ba,
    input wire logic [AW-1:0] addr,
    // data pins
    input wire logic [DW/8-1:0] dqm,
    input wire logic [DW-1:0] dq_i,
    output logic [DW-1:0] dq_o,
    output logic [DW/8-1:0] dq_oe,
    // status
    output logic spacing_err,
    output logic refresh_short,
    output logic init_done,
    output logic suspended,
    output logic [3:0] bank_open
);
    localparam int NB = DW / 8;
    localparam int IW = COL_BITS + 2;
    localparam logic [3:0] AP_LOAD =
        4'(1 + `SDC_WRITE_RECOVERY_CYC + `SDC_PRECHARGE_PERIOD_CYC);

    sdc_cmd_t cmd;
    sdc_pwr_t pw_ff, nxt_pw;
    logic take, cke_q_ff, cl3_ff, ap_ff, wap_ff, sref_pend_ff, err_ff, short_ff, init_ff;
    logic col_cmd, cont, wr_now, rd_now, last_wr, nxt_err, susp_ff;
    logic [3:0] bl_ff, wr_cnt_ff, rd_cnt_ff, since_wd_ff, since_lmr_ff, ap_tmr_ff, open_ff;
    logic [1:0] bank_ff, wbank_ff, sref_edges_ff;
    logic [COL_BITS-1:0] col_ff;
    logic [IW-1:0] wr_idx, rd_idx;
    logic [DW-1:0] mem [0:2**IW-1];
    logic [DW-1:0] wr_old;
    logic [31:0] win_cnt_ff;
    logic [15:0] ref_cnt_ff;

    // pin code to command; cs high means inhibit
    function automatic sdc_cmd_t sdc_decode(input logic [3:0] code);
        case (code)
            `SDC_CODE_NOP: return CMD_NOP;
            `SDC_CODE_ACTIVE: return CMD_ACTIVE;
            `SDC_CODE_READ: return CMD_READ;
            `SDC_CODE_WRITE: return CMD_WRITE;
            `SDC_CODE_BST: return CMD_BST;
            `SDC_CODE_PRECH: return CMD_PRECH;
            `SDC_CODE_REFRESH: return CMD_REFRESH;
            `SDC_CODE_LMR: return CMD_LMR;
            default: return CMD_INHIBIT;
        endcase
    endfunction

    // true when fewer clocks than need have passed since the event
    function automatic logic gap_short(input logic [3:0] since, input int need);
        return ({1'b0, since} + 5'h01) < 5'(need);
    endfunction

    // command decode and burst continuation
    assign cmd = sdc_decode({cs_n, ras_n, cas_n, we_n});
    assign take = cke_q_ff;
    assign col_cmd = (cmd == CMD_READ) || (cmd == CMD_WRITE);
    assign cont = take && !col_cmd && (cmd != CMD_BST) && (cmd != CMD_PRECH);
    assign wr_idx = (cmd == CMD_WRITE) ? {ba, addr[COL_BITS-1:0]} : {bank_ff, col_ff};
    assign rd_idx = (cmd == CMD_READ) ? {ba, addr[COL_BITS-1:0]} : {bank_ff, col_ff};
    assign wr_now = (take && cmd == CMD_WRITE) || (cont && wr_cnt_ff != 4'h0);
    assign rd_now = (take && cmd == CMD_READ) || (cont && rd_cnt_ff != 4'h0);
    assign last_wr = wr_now && ((cmd == CMD_WRITE) ? (bl_ff == 4'h1) : (wr_cnt_ff == 4'h1));
    assign wr_old = mem[wr_idx];

    // clock gate sampled one edge ahead of command taking
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cke_q_ff <= 1'b0;
        end else begin
            cke_q_ff <= cke;
        end
    end

    // power state: run, clock suspend or power-down, self refresh
    always_comb begin
        nxt_pw = pw_ff;
        case (pw_ff)
            PW_RUN: begin
                if (take && !cke && cmd == CMD_REFRESH) begin
                    nxt_pw = PW_SELFREF;
                end else if (!cke) begin
                    nxt_pw = PW_SUSPEND;
                end
            end
            PW_SUSPEND: if (cke) nxt_pw = PW_RUN;
            PW_SELFREF: if (cke) nxt_pw = PW_RUN;
            default: nxt_pw = PW_RUN;
        endcase
    end

    // state flop plus a registered copy so the status pin leaves a flop
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pw_ff <= PW_RUN;
            susp_ff <= 1'b0;
        end else begin
            pw_ff <= nxt_pw;
            susp_ff <= (nxt_pw != PW_RUN);
        end
    end

    // mode word: burst length and read latency
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cl3_ff <= `SDC_RESET_CL3;
            bl_ff <= `SDC_RESET_BL;
            init_ff <= 1'b0;
        end else if (take && cmd == CMD_LMR) begin
            cl3_ff <= addr[`SDC_MODE_CL_LSB +: 3] != 3'h2;
            case (addr[`SDC_MODE_BL_LSB +: 3])
                3'h1: bl_ff <= 4'h2;
                3'h2: bl_ff <= 4'h4;
                3'h3: bl_ff <= 4'h8;
                default: bl_ff <= 4'h1;
            endcase
            init_ff <= 1'b1;
        end
    end

    // burst counters; a new column command or stop cuts the old burst
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_cnt_ff <= 4'h0;
            rd_cnt_ff <= 4'h0;
            col_ff <= '0;
            bank_ff <= 2'h0;
            ap_ff <= 1'b0;
        end else if (take && col_cmd) begin
            wr_cnt_ff <= (cmd == CMD_WRITE) ? bl_ff - 4'h1 : 4'h0;
            rd_cnt_ff <= (cmd == CMD_READ) ? bl_ff - 4'h1 : 4'h0;
            col_ff <= COL_BITS'(addr[COL_BITS-1:0] + 1'b1);
            bank_ff <= ba;
            ap_ff <= addr[`SDC_AP_BIT];
        end else if (take && (cmd == CMD_BST || cmd == CMD_PRECH)) begin
            wr_cnt_ff <= 4'h0;
            rd_cnt_ff <= 4'h0;
        end else if (cont) begin
            if (wr_cnt_ff != 4'h0) wr_cnt_ff <= wr_cnt_ff - 4'h1;
            if (rd_cnt_ff != 4'h0) rd_cnt_ff <= rd_cnt_ff - 4'h1;
            col_ff <= COL_BITS'(col_ff + 1'b1);
        end
    end

    // array write with same-edge byte mask
    always_ff @(posedge clk) begin
        if (wr_now) begin
            for (int b = 0; b < NB; b++) begin
                if (!dqm[b]) mem[wr_idx][8*b +: 8] <= dq_i[8*b +: 8];
            end
        end
    end

    // read path into the output pipeline
    sdc_rd_if #(.DW(DW)) rd_bus ();
    assign rd_bus.fire = rd_now;
    assign rd_bus.adv = take;
    assign rd_bus.cl3 = cl3_ff;
    assign rd_bus.data = mem[rd_idx];
    assign rd_bus.mask = dqm;

    sdc_rd_pipe #(.DW(DW)) u_rd_pipe (
        .clk(clk),
        .resetn(resetn),
        .rd(rd_bus)
    );

    // per-gap counters: since write data and since mode load
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            since_wd_ff <= 4'hF;
            since_lmr_ff <= 4'hF;
            wbank_ff <= 2'h0;
            wap_ff <= 1'b0;
        end else begin
            if (wr_now) begin
                since_wd_ff <= 4'h0;
                wbank_ff <= (cmd == CMD_WRITE) ? ba : bank_ff;
                wap_ff <= (cmd == CMD_WRITE) ? addr[`SDC_AP_BIT] : ap_ff;
            end else if (since_wd_ff != 4'hF) begin
                since_wd_ff <= since_wd_ff + 4'h1;
            end
            if (take && cmd == CMD_LMR) since_lmr_ff <= 4'h0;
            else if (since_lmr_ff != 4'hF) since_lmr_ff <= since_lmr_ff + 4'h1;
        end
    end

    // edges seen since leaving self refresh
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sref_pend_ff <= 1'b0;
            sref_edges_ff <= 2'h0;
        end else if (pw_ff == PW_SELFREF && cke) begin
            sref_pend_ff <= 1'b1;
            sref_edges_ff <= 2'h0;
        end else if (take && cmd == CMD_ACTIVE) begin
            sref_pend_ff <= 1'b0;
        end else if (sref_edges_ff != 2'h3) begin
            sref_edges_ff <= sref_edges_ff + 2'h1;
        end
    end

    // spacing violations from the controller; forbidden slots need no-op
    always_comb begin
        nxt_err = 1'b0;
        if (take && cmd == CMD_PRECH && (addr[`SDC_AP_BIT] || ba == wbank_ff)
                && gap_short(since_wd_ff, `SDC_DATA_TO_PRECHARGE_GAP)) begin
            nxt_err = 1'b1;
        end
        if (take && cmd == CMD_ACTIVE && wap_ff && ba == wbank_ff
                && gap_short(since_wd_ff, `SDC_DATA_TO_ACTIVATE_GAP)) begin
            nxt_err = 1'b1;
        end
        if (take && (cmd == CMD_ACTIVE || cmd == CMD_REFRESH)
                && gap_short(since_lmr_ff, `SDC_MODE_LOAD_GAP)) begin
            nxt_err = 1'b1;
        end
        if (take && cmd == CMD_ACTIVE && sref_pend_ff
                && {2'h0, sref_edges_ff} < 4'(`SDC_SREF_EXIT_EDGES)) begin
            nxt_err = 1'b1;
        end
        if (take && (cmd == CMD_ACTIVE || col_cmd) && !init_ff) begin
            nxt_err = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) err_ff <= 1'b0;
        else err_ff <= nxt_err;
    end

    // open rows; auto precharge closes after recovery plus precharge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            open_ff <= 4'h0;
            ap_tmr_ff <= 4'h0;
        end else begin
            if (last_wr && ((cmd == CMD_WRITE) ? addr[`SDC_AP_BIT] : ap_ff)) begin
                ap_tmr_ff <= AP_LOAD;
            end else if (ap_tmr_ff != 4'h0) begin
                ap_tmr_ff <= ap_tmr_ff - 4'h1;
            end
            if (ap_tmr_ff == 4'h1) open_ff[wbank_ff] <= 1'b0;
            if (take && cmd == CMD_ACTIVE) open_ff[ba] <= 1'b1;
            else if (take && cmd == CMD_PRECH && addr[`SDC_AP_BIT]) open_ff <= 4'h0;
            else if (take && cmd == CMD_PRECH) open_ff[ba] <= 1'b0;
        end
    end

    // refresh budget per window; self refresh counts as covered
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            win_cnt_ff <= 32'h0;
            ref_cnt_ff <= 16'h0;
            short_ff <= 1'b0;
        end else if (win_cnt_ff == 32'(REF_WINDOW_CYC - 1)) begin
            win_cnt_ff <= 32'h0;
            ref_cnt_ff <= 16'h0;
            if (ref_cnt_ff < 16'(REF_COUNT)) short_ff <= 1'b1;
        end else begin
            win_cnt_ff <= win_cnt_ff + 32'h1;
            if (pw_ff == PW_SELFREF) ref_cnt_ff <= 16'(REF_COUNT);
            else if (take && cke && cmd == CMD_REFRESH && ref_cnt_ff != 16'hFFFF)
                ref_cnt_ff <= ref_cnt_ff + 16'h1;
        end
    end

    // outputs straight from flops
    assign dq_o = rd_bus.dq_o;
    assign dq_oe = rd_bus.dq_oe;
    assign spacing_err = err_ff;
    assign refresh_short = short_ff;
    assign init_done = init_ff;
    assign suspended = susp_ff;
    assign bank_open = open_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_suspend_entry;
        (!take && wr_cnt_ff != 4'h0) |=> $stable(wr_cnt_ff);
    endproperty
    a_suspend_entry: assert property (p_suspend_entry)
        else $error("burst advanced on a suspended clock");

    property p_suspend_exit;
        (!cke_q_ff && cke) ##1 (cmd == CMD_ACTIVE) |=> open_ff[$past(ba)];
    endproperty
    a_suspend_exit: assert property (p_suspend_exit)
        else $error("command after gate release not taken");

    property p_write_same_edge;
        (take && cmd == CMD_WRITE && dqm == '0) |=> mem[$past(wr_idx)] == $past(dq_i);
    endproperty
    a_write_same_edge: assert property (p_write_same_edge)
        else $error("first write data not taken on command edge");

    property p_write_mask;
        (wr_now && dqm[0]) |=> mem[$past(wr_idx)][7:0] == $past(wr_old[7:0]);
    endproperty
    a_write_mask: assert property (p_write_mask)
        else $error("masked write byte was stored");

    property p_prech_off_cl2;
        (take && cmd == CMD_PRECH && !cl3_ff) ##1 (take && cmd != CMD_READ)
            |=> dq_oe == '0;
    endproperty
    a_prech_off_cl2: assert property (p_prech_off_cl2)
        else $error("outputs on two clocks after precharge");

    property p_prech_off_cl3;
        (take && cmd == CMD_PRECH && cl3_ff) ##1 (take && cmd != CMD_READ) [*2]
            |=> dq_oe == '0;
    endproperty
    a_prech_off_cl3: assert property (p_prech_off_cl3)
        else $error("outputs on three clocks after precharge");

    property p_mode_gap;
        (take && cmd == CMD_LMR) ##1 (take && cmd == CMD_ACTIVE) |=> err_ff;
    endproperty
    a_mode_gap: assert property (p_mode_gap)
        else $error("activate right after mode load not flagged");

    property p_prech_gap;
        wr_now ##1 (take && cmd == CMD_PRECH && addr[10]) |=> err_ff;
    endproperty
    a_prech_gap: assert property (p_prech_gap)
        else $error("early precharge after write data not flagged");

    property p_ap_close;
        (last_wr && (cmd == CMD_WRITE ? addr[10] : ap_ff) && !(take && cmd == CMD_ACTIVE))
            ##1 (!(take && cmd == CMD_ACTIVE)) [*3] |=> !open_ff[$past(wbank_ff)];
    endproperty
    a_ap_close: assert property (p_ap_close)
        else $error("auto precharge did not close the bank in time");
endmodule // sdc_device

// ==== test/sdc_ctl_model.sv ====
// controller stand-in: drives command, clock gate, mask and write data pins
// assumes the bench calls its tasks and shares clk with the device
`timescale 1ns/1ps
`include "sdc_params.svh"
module sdc_ctl_model (
    // clock
    input wire logic clk,
    // command pins
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [1:0] ba,
    output logic [12:0] addr,
    // data pins
    output logic [3:0] dqm,
    output logic [31:0] dq
);
    // idle pins from time zero: gate on, no-operation
    initial begin
        cke = 1'b1;
        {cs_n, ras_n, cas_n, we_n} = `SDC_CODE_NOP;
        ba = 2'h0;
        addr = 13'h0000;
        dqm = 4'h0;
        dq = 32'h0;
    end

    // one command slot; the bench spaces slots, leaving the precharge and activate gaps short on purpose in t_spacing
    task automatic cmd(input logic [3:0] code, input logic [1:0] b,
                       input logic [12:0] a, input logic [31:0] d, input logic [3:0] m);
        @(negedge clk);
        {cs_n, ras_n, cas_n, we_n} = code;
        ba = b;
        addr = a;
        dq = d;
        dqm = m;
    endtask

    // clock gate change; the clock itself never stops
    task automatic gate(input logic on);
        @(negedge clk);
        cke = on;
    endtask
endmodule // sdc_ctl_model

// ==== test/tb_sdc_device.sv ====
// bench for the sdram device core: spacing, masks, suspend, refresh budget
// assumes sdc_ctl_model drives the pins; refresh window shortened to 64
`timescale 1ns/1ps
`include "sdc_params.svh"
module tb_sdc_device;
    logic clk, resetn, cke, cs_n, ras_n, cas_n, we_n;
    logic [1:0] ba;
    logic [12:0] addr;
    logic [3:0] dqm, dq_oe, bank_open;
    logic [31:0] dq_i, dq_o, idle;
    logic spacing_err, refresh_short, init_done, suspended;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;

    sdc_ctl_model u_ctl (.clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm), .dq(dq_i));
    sdc_device #(.REF_WINDOW_CYC(64), .REF_COUNT(2)) DUT (.clk(clk), .resetn(resetn),
        .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
        .addr(addr), .dqm(dqm), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe),
        .spacing_err(spacing_err), .refresh_short(refresh_short), .init_done(init_done),
        .suspended(suspended), .bank_open(bank_open));

    // 25 MHz clock
    initial clk = 1'b0;
    always #20 clk = ~clk;

    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            n_errors = n_errors + 1;
            summarize();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // no-operation slot with a data pattern that flips on every call
    task automatic nop();
        idle = ~idle;
        u_ctl.cmd(`SDC_CODE_NOP, 2'h0, 13'h0000, idle, 4'h0);
    endtask

    task automatic t_init();
        u_ctl.cmd(`SDC_CODE_LMR, 2'h0, 13'h0021, idle, 4'h0); // burst 2, latency 2
        nop();
        u_ctl.cmd(`SDC_CODE_REFRESH, 2'h0, 13'h0000, idle, 4'h0);
        u_ctl.cmd(`SDC_CODE_REFRESH, 2'h0, 13'h0000, idle, 4'h0);
        u_ctl.cmd(`SDC_CODE_ACTIVE, 2'h0, 13'h0010, idle, 4'h0);
        nop();
        check("bank_open", {28'h0, bank_open}, 32'h1);
        check("init_done", {31'h0, init_done}, 32'h1);
        check("gap_ok", {31'h0, spacing_err}, 32'h0);
        $display("t_init done");
    endtask

    task automatic t_rw();
        u_ctl.cmd(`SDC_CODE_WRITE, 2'h0, 13'h0000, 32'h11223344, 4'h0);
        u_ctl.cmd(`SDC_CODE_NOP, 2'h0, 13'h0000, 32'h55667788, 4'h0);
        u_ctl.cmd(`SDC_CODE_WRITE, 2'h0, 13'h0000, 32'h99AABBCC, 4'h3);
        u_ctl.cmd(`SDC_CODE_READ, 2'h0, 13'h0001, idle, 4'h0);
        u_ctl.cmd(`SDC_CODE_READ, 2'h0, 13'h0000, idle, 4'h0);
        u_ctl.cmd(`SDC_CODE_NOP, 2'h0, 13'h0000, idle, 4'h1);
        check("rd_first", dq_o, 32'h55667788);
        nop();
        check("rd_masked_wr", dq_o, 32'h99AA3344);
        check("rd_oe", {28'h0, dq_oe}, 32'hF);
        nop();
        check("rd_mask_oe", {28'h0, dq_oe}, 32'hE);
        nop();
        check("rd_end_oe", {28'h0, dq_oe}, 32'h0);
        $display("t_rw done");
    endtask

    task automatic t_spacing();
        u_ctl.cmd(`SDC_CODE_WRITE, 2'h0, 13'h0002, 32'h0F0F0F0F, 4'h0);
        u_ctl.cmd(`SDC_CODE_NOP, 2'h0, 13'h0000, 32'hF0F0F0F0, 4'h0);
        u_ctl.cmd(`SDC_CODE_PRECH, 2'h0, 13'h0400, idle, 4'h0); // one clock short
        nop();
        check("early_prech", {31'h0, spacing_err}, 32'h1);
        nop();
        check("err_pulse", {31'h0, spacing_err}, 32'h0);
        nop();
        u_ctl.cmd(`SDC_CODE_ACTIVE, 2'h0, 13'h0010, idle, 4'h0);
        nop();
        u_ctl.cmd(`SDC_CODE_WRITE, 2'h0, 13'h0400, 32'h01234567, 4'h0); // auto precharge
        u_ctl.cmd(`SDC_CODE_NOP, 2'h0, 13'h0000, 32'h89ABCDEF, 4'h0);
        nop();
        nop();
        nop();
        u_ctl.cmd(`SDC_CODE_ACTIVE, 2'h0, 13'h0010, idle, 4'h0); // four clocks after data
        check("ap_closed", {28'h0, bank_open}, 32'h0);
        nop();
        check("early_active", {31'h0, spacing_err}, 32'h1);
        nop();
        $display("t_spacing done");
    endtask

    task automatic t_suspend();
        // gate drops on the edge that takes a write, so its burst is frozen
        fork
            u_ctl.gate(1'b0);
            u_ctl.cmd(`SDC_CODE_WRITE, 2'h0, 13'h0004, 32'h0A0B0C0D, 4'h0);
        join
        u_ctl.cmd(`SDC_CODE_ACTIVE, 2'h2, 13'h0030, idle, 4'h0); // ignored
        nop();
        check("suspend_in", {31'h0, suspended}, 32'h1);
        u_ctl.gate(1'b1);
        u_ctl.cmd(`SDC_CODE_ACTIVE, 2'h1, 13'h0020, idle, 4'h0);
        check("suspend_out", {31'h0, suspended}, 32'h0);
        nop();
        check("resume_cmd", {28'h0, bank_open}, 32'h3);
        $display("t_suspend done");
    endtask

    task automatic t_refresh();
        repeat (30) @(negedge clk);
        check("refresh_met", {31'h0, refresh_short}, 32'h0);
        repeat (64) @(negedge clk);
        check("refresh_short", {31'h0, refresh_short}, 32'h1);
        $display("t_refresh done");
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        resetn = 1'b0;
        idle = 32'h5A5AA5A5;
        repeat (4) @(posedge clk);
        @(negedge clk);
        resetn = 1'b1;
        nop();
        t_init();
        t_rw();
        t_spacing();
        t_suspend();
        t_refresh();
        summarize();
    end
endmodule // tb_sdc_device
